// ### logic/timer_pwm_out.sv
// timer A complementary pwm output stage, pin polarity and count prescaler
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
module timer_pwm_out
  import timer_pwm_pkg::*;
#(
  parameter int DIV_CODE_LIMIT = DIV_CODE_MAX
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [31:0]       rdata,
  input  wire logic              pwm_raw,
  input  wire logic              pwm_raw_ckb,
  input  wire logic              pin_routed,
  input  wire logic              pin_in,
  output logic                   pwm_pri,
  output logic                   pwm_ckb,
  output logic                   pin_out,
  output logic                   pin_in_act,
  output logic                   sync_en,
  output logic                   cnt_tick
);
  // refuse limits that the prescaler counter or the code field cannot serve
  if (DIV_CODE_LIMIT < 0 || DIV_CODE_LIMIT > PRESC_W ||
      DIV_CODE_LIMIT >= (1 << DIV_W)) begin : g_bad_limit
    $error("DIV_CODE_LIMIT out of range");
  end

  logic               ckb_dis_q;
  logic               ckb_pol_q;
  logic               pri_pol_q;
  logic               sync_q;
  logic               pin_pol_q;
  logic [DIV_W-1:0]   div_q;
  logic [DIV_W-1:0]   div_wr;
  logic               div_ok;
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] mask;
  logic [31:0]        ctrl;
  logic [31:0]        rd_word;
  logic               wr_ctrl;
  logic               tick_d;

  // a write while clk_en is low is dropped, not held for later
  assign wr_ctrl = clk_en && wr_stb && addr == OFF_CTRL_ZERO;

  // reserved codes keep the previous divider, never a bogus ratio
  always_comb begin
    div_wr = wdata[POS_DIV_LO +: DIV_W];
    div_ok = div_wr <= DIV_W'(DIV_CODE_LIMIT);
  end

  // one register per field, so each keeps its own reset value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ckb_dis_q <= RST_CKB_DIS;
    end else if (wr_ctrl) begin
      ckb_dis_q <= wdata[POS_CKB_DIS];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ckb_pol_q <= RST_CKB_POL;
    end else if (wr_ctrl) begin
      ckb_pol_q <= wdata[POS_CKB_POL];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pri_pol_q <= RST_PRI_POL;
    end else if (wr_ctrl) begin
      pri_pol_q <= wdata[POS_PRI_POL];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_q <= RST_SYNC_EN;
    end else if (wr_ctrl) begin
      sync_q <= wdata[POS_SYNC_EN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_pol_q <= RST_PIN_POL;
    end else if (wr_ctrl) begin
      pin_pol_q <= wdata[POS_PIN_POL];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_q <= RST_DIV;
    end else if (wr_ctrl && div_ok) begin
      div_q <= div_wr;
    end
  end

  // control word as software reads it back; unused bits read zero
  always_comb begin
    ctrl = 32'h0;
    ctrl[POS_CKB_DIS]          = ckb_dis_q;
    ctrl[POS_CKB_POL]          = ckb_pol_q;
    ctrl[POS_PRI_POL]          = pri_pol_q;
    ctrl[POS_SYNC_EN]          = sync_q;
    ctrl[POS_PIN_POL]          = pin_pol_q;
    ctrl[POS_DIV_LO +: DIV_W]  = div_q;
  end

  // unmapped offsets read as zero
  always_comb begin
    rd_word = 32'h0;
    case (addr)
      OFF_CTRL_ZERO: rd_word = ctrl;
      OFF_PWM_IN:    rd_word = {29'h0, pin_in_act, pwm_ckb, pwm_pri};
      default:       rd_word = 32'h0;
    endcase
  end

  // read data stand for one enabled cycle only, then fall back to zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (clk_en) begin
      rdata <= rd_stb ? rd_word : 32'h0;
    end
  end

  // free-running, not cleared on a code change: the first period after a
  // change may be short, traded for a counter that is a single adder
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      presc_q <= '0;
    end else if (clk_en) begin
      presc_q <= presc_q + PRESC_W'(1);
    end
  end

  // the low div_q bits of presc_q all ones mark the last source cycle of a count period
  always_comb begin
    mask = '0;
    for (int b = 0; b < PRESC_W; b++) begin
      mask[b] = b < int'(div_q);
    end
  end

  assign tick_d = (presc_q & mask) == mask;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_tick <= 1'b0;
    end else if (clk_en) begin
      cnt_tick <= tick_d;
    end
  end

  // outputs are registered: a setting written at one edge shows at the outputs on the next edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwm_pri <= PIN_IDLE;
    end else if (clk_en) begin
      pwm_pri <= pwm_raw ^ pri_pol_q;
    end
  end

  // disable wins over inversion so the output idles low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwm_ckb <= PIN_IDLE;
    end else if (clk_en) begin
      if (ckb_dis_q) begin
        pwm_ckb <= PIN_IDLE;
      end else begin
        pwm_ckb <= pwm_raw_ckb ^ ckb_pol_q;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_out <= PIN_IDLE;
    end else if (clk_en) begin
      if (pin_routed) begin
        pin_out <= pwm_raw ^ pin_pol_q;
      end else begin
        pin_out <= PIN_IDLE;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_in_act <= PIN_IDLE;
    end else if (clk_en) begin
      if (pin_routed) begin
        pin_in_act <= pin_in ^ pin_pol_q;
      end else begin
        pin_in_act <= PIN_IDLE;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_en <= RST_SYNC_EN;
    end else if (clk_en) begin
      sync_en <= sync_q;
    end
  end
endmodule

// ### logic/timer_pwm_pkg.sv
// package: register map, field positions and reset values of the timer control
package timer_pwm_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_CTRL_ZERO   = 8'h10;
  localparam logic [7:0]  OFF_PWM_IN      = 8'h20;
  localparam int          POS_CKB_DIS     = 12;
  localparam int          POS_CKB_POL     = 11;
  localparam int          POS_PRI_POL     = 10;
  localparam int          POS_SYNC_EN     = 9;
  localparam int          POS_PIN_POL     = 8;
  localparam int          POS_DIV_LO      = 4;
  localparam int          DIV_W           = 4;
  localparam logic        RST_CKB_DIS     = 1'b1;
  localparam logic        RST_CKB_POL     = 1'b0;
  localparam logic        RST_PRI_POL     = 1'b0;
  localparam logic        RST_SYNC_EN     = 1'b0;
  localparam logic        RST_PIN_POL     = 1'b0;
  localparam logic [3:0]  RST_DIV         = 4'h0;
  localparam logic        PIN_IDLE        = 1'b0;
  localparam logic [3:0]  DIV_CODE_MAX    = 4'h8;
  localparam int          PRESC_W         = 8;
endpackage

// ### sim/timer_pwm_assertions.sv
// checker: control readback tied to pwm, pin, sync and prescaler outputs
`timescale 1ns/1ns
module timer_pwm_chk
  import timer_pwm_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              clk_en,
  input wire logic              rd_stb,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0]       rdata,
  input wire logic              pwm_raw,
  input wire logic              pwm_raw_ckb,
  input wire logic              pin_routed,
  input wire logic              pin_in,
  input wire logic              pwm_pri,
  input wire logic              pwm_ckb,
  input wire logic              pin_out,
  input wire logic              pin_in_act,
  input wire logic              sync_en,
  input wire logic              cnt_tick
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a control read taken at this edge; outputs and readback then both
  // reflect the same settled control word one edge later
  sequence rd_s;
    clk_en && rd_stb && addr == OFF_CTRL_ZERO;
  endsequence
  rd_idle_a: assert property (clk_en && !rd_stb |=> rdata == 32'h0)
    else $error("rdata not idle");
  sync_copy_a: assert property (rd_s |=>
    sync_en == rdata[POS_SYNC_EN]) else $error("sync differs");
  ckb_off_a: assert property (rd_s ##1 rdata[POS_CKB_DIS] |->
    !pwm_ckb) else $error("ckb not off");
  ckb_pol_a: assert property (rd_s ##1 !rdata[POS_CKB_DIS] |->
    pwm_ckb == ($past(pwm_raw_ckb) ^ rdata[POS_CKB_POL]))
    else $error("ckb pol");
  pri_pol_a: assert property (rd_s |=>
    pwm_pri == ($past(pwm_raw) ^ rdata[POS_PRI_POL]))
    else $error("pri pol");
  pin_off_a: assert property (clk_en && !pin_routed |=>
    !pin_out && !pin_in_act) else $error("pin not off");
  pin_pol_a: assert property ((rd_s and pin_routed) |=>
    pin_in_act == ($past(pin_in) ^ rdata[POS_PIN_POL]) &&
    pin_out == ($past(pwm_raw) ^ rdata[POS_PIN_POL]))
    else $error("pin pol");
  div_ok_a: assert property (rd_s |=>
    rdata[POS_DIV_LO +: DIV_W] <= DIV_CODE_MAX) else $error("bad divider");
  tick_full_a: assert property (rd_s ##1
    rdata[POS_DIV_LO +: DIV_W] == 4'h0 |-> cnt_tick)
    else $error("tick missing at code 0");
  // with clk_en low nothing that the design drives may move
  freeze_hold_a: assert property (!clk_en |=> $stable(rdata) &&
    $stable(pwm_pri) && $stable(pwm_ckb) && $stable(pin_out) &&
    $stable(pin_in_act) && $stable(sync_en) && $stable(cnt_tick))
    else $error("output moved while frozen");
endmodule
bind timer_pwm_out timer_pwm_chk i_timer_pwm_chk(
  .clk_sys     (clk_sys),
  .rst         (rst),
  .clk_en      (clk_en),
  .rd_stb      (rd_stb),
  .addr        (addr),
  .rdata       (rdata),
  .pwm_raw     (pwm_raw),
  .pwm_raw_ckb (pwm_raw_ckb),
  .pin_routed  (pin_routed),
  .pin_in      (pin_in),
  .pwm_pri     (pwm_pri),
  .pwm_ckb     (pwm_ckb),
  .pin_out     (pin_out),
  .pin_in_act  (pin_in_act),
  .sync_en     (sync_en),
  .cnt_tick    (cnt_tick)
);

// ### sim/timer_pwm_out_test.sv
// bench: random control writes, readback, status and prescaler counts
`timescale 1ns/1ns
module timer_pwm_out_test;
  import timer_pwm_pkg::*;
  logic        clk_sys = 0, rst = 1, wr_stb = 0, rd_stb = 0, pend = 0;
  logic        clk_en = 1'b1;
  logic        pwm_raw = 0, pwm_raw_ckb = 0, pin_routed = 0, pin_in = 0;
  logic        pwm_pri, pwm_ckb, pin_out, pin_in_act, sync_en, cnt_tick;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, ctl, ticks, lf = 32'h719622cc;
  logic [31:0] exp_q[$];
  int          n_errors = 0, checked = 0;
  always #4 clk_sys = ~clk_sys;
  timer_pwm_out i_timer_pwm_out(
    .clk_sys     (clk_sys),
    .rst         (rst),
    .clk_en      (clk_en),
    .addr        (addr),
    .wdata       (wdata),
    .wr_stb      (wr_stb),
    .rd_stb      (rd_stb),
    .rdata       (rdata),
    .pwm_raw     (pwm_raw),
    .pwm_raw_ckb (pwm_raw_ckb),
    .pin_routed  (pin_routed),
    .pin_in      (pin_in),
    .pwm_pri     (pwm_pri),
    .pwm_ckb     (pwm_ckb),
    .pin_out     (pin_out),
    .pin_in_act  (pin_in_act),
    .sync_en     (sync_en),
    .cnt_tick    (cnt_tick)
  );
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // strobes stay as set until the next call, so back to back is clean
  task automatic bus(logic w, logic r, logic [7:0] a, logic [31:0] d);
    wr_stb <= w;
    rd_stb <= r;
    addr <= a;
    wdata <= d;
    if (r) exp_q.push_back(d);
    @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    if (pend) chk(rdata, exp_q.pop_front());
    pend <= rd_stb && clk_en && !rst;
  end
  task automatic summarize;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    ctl = 32'h1000;
    bus(0, 1, OFF_CTRL_ZERO, ctl);
    // codes 9..15 must leave the divider unchanged
    for (int i = 0; i < 16; i++) begin
      lf = nxt(lf);
      {pwm_raw, pwm_raw_ckb, pin_routed, pin_in} <= lf[19:16];
      bus(1, 0, OFF_CTRL_ZERO, {lf[31:8], i[3:0], lf[3:0]});
      bus(1, 0, 8'h30, ~lf);
      if (i > 8) ctl = {19'h0, lf[12:8], ctl[7:4], 4'h0};
      else ctl = {19'h0, lf[12:8], i[3:0], 4'h0};
      bus(0, 0, 8'h0, 32'h0);
      bus(0, 1, OFF_CTRL_ZERO, ctl);
      bus(0, 1, OFF_PWM_IN, {29'h0, pin_routed & (pin_in ^ ctl[8]),
        !ctl[12] & (pwm_raw_ckb ^ ctl[11]), pwm_raw ^ ctl[10]});
      bus(0, 1, 8'h44, 32'h0);
      bus(0, 0, 8'h0, 32'h0);
      ticks = 0;
      repeat (256) begin
        @(posedge clk_sys);
        ticks += {31'h0, cnt_tick};
      end
      chk(ticks, 32'd256 >> ctl[7:4]);
    end
    // a write while clk_en is low must be lost; inputs move meanwhile
    clk_en <= 1'b0;
    {pwm_raw, pwm_raw_ckb, pin_routed, pin_in} <= ~lf[19:16];
    bus(1, 0, OFF_CTRL_ZERO, ~ctl);
    bus(0, 0, 8'h0, 32'h0);
    repeat (4) @(posedge clk_sys);
    clk_en <= 1'b1;
    bus(0, 1, OFF_CTRL_ZERO, ctl);
    bus(0, 0, 8'h0, 32'h0);
    // mid-run reset brings back the power-on control word
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    bus(0, 1, OFF_CTRL_ZERO, {19'h0, RST_CKB_DIS, RST_CKB_POL, RST_PRI_POL,
      RST_SYNC_EN, RST_PIN_POL, RST_DIV, 4'h0});
    bus(0, 0, 8'h0, 32'h0);
    chk({31'h0, pwm_ckb}, {31'h0, PIN_IDLE});
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    summarize;
  end
endmodule
